// ===== rtl/mgmt_port_device.sv
// Purpose: device end of the management bus, 32 byte registers
// Assumes: bus pins asynchronous, sampled on a 12.5 MHz enable
// Notes:   ack held while select stays low; odd parity on data
//
// Functional notes
// R1: cycle starts only while select is low
// R2: direction high reads, low writes
// R3: acknowledge low marks cycle completion
// R4: read data driven while acknowledge low
// R5: host holds write data until acknowledge
// R6: acknowledge stays low while select low
// R7: thirty-two byte-wide internal registers
// R8: five-bit address selects the register
// R9: unmasked conditions pull interrupt low
// R10: host reads condition register for cause
// R11: parity-enable input switches write checking
// R12: read parity generated regardless of enable
// R13: odd parity over eight data bits
// R14: read parity held while acknowledge low
// R15: bad write parity inhibits, sets flag
// R16: select high releases acknowledge and bus
// R17: inputs synchronised, sampled on 12.5 MHz enable
`timescale 1ns/1ps
module mgmt_port_device
  import mgmt_bus_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // bus pins
  mgmt_bus_if.device      bus,
  // user side
  input  wire logic       write_parity_check_en_i,
  input  wire logic [7:0] cond_events_i,
  output logic      [7:0] cond_status_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ACK  = 3'b010,
    ST_WAIT = 3'b100
  } dev_state_t;

  // refuse package settings that the sampling enable or the decode cannot serve
  if (SAMPLE_HZ >= CLK_HZ || SAMPLE_HZ <= 0) begin : g_bad_rate
    $error("sample rate must lie below the clock rate");
  end
  if (NUM_REGS != (1 << ADDR_W) || DATA_W != 8) begin : g_bad_size
    $error("register file must be fully decoded bytes");
  end

  // phase accumulator for the 12.5 MHz sampling enable
  localparam logic [4:0] PHASE_STEP = 5'(SAMPLE_HZ * 32 / CLK_HZ);
  logic [4:0] phase_reg;
  logic [4:0] phase_next;
  logic       sample_en;

  // two-stage synchronisers for all asynchronous bus inputs
  localparam int SYNC_W = 1 + 1 + 5 + 8 + 1 + 1;
  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;
  logic [SYNC_W-1:0] pins;
  logic              sel_s;
  logic              rdwr_s;
  logic [4:0]        addr_s;
  logic [7:0]        data_s;
  logic              par_s;
  logic              pen_s;

  dev_state_t state_reg;
  dev_state_t state_next;
  // R7: thirty-two byte registers
  logic [7:0] regs_reg [NUM_REGS];
  logic [7:0] regs_next [NUM_REGS];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       oe_reg;
  logic       oe_next;
  logic       ack_reg;
  logic       ack_next;
  logic       int_reg;
  logic       int_next;
  logic       par_reg;
  logic       par_next;
  logic       par_ok;

  assign pins = {bus.sel_n, bus.rd_wr, bus.mgmt_addr, bus.mgmt_data, bus.mgmt_parity,
                 write_parity_check_en_i};
  assign {sel_s, rdwr_s, addr_s, data_s, par_s, pen_s} = sync_reg;

  // phase accumulator: each overflow marks one 12.5 MHz sample slot
  always_comb begin
    phase_next = phase_reg + PHASE_STEP;
    sample_en  = (phase_next < phase_reg);
  end

  // phase register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= 5'h00;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // R17: synchronise then sample
  // resets to idle pin levels, so no false select follows reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= {SYNC_W{1'b1}};
      sync_reg <= {SYNC_W{1'b1}};
    end else begin
      meta_reg <= pins;
      sync_reg <= meta_reg;
    end
  end

  // R13: odd parity means nine bits hold an odd count of ones
  assign par_ok = ^{data_s, par_s};

  // next-state and register file
  always_comb begin
    state_next = state_reg;
    regs_next  = regs_reg;
    rdata_next = rdata_reg;
    oe_next    = oe_reg;
    ack_next   = ack_reg;
    // R9: latch events sticky, set wins
    regs_next[ICR_ADDR] = regs_reg[ICR_ADDR] | cond_events_i;
    if (sample_en) begin
      case (state_reg)
        ST_IDLE: begin
          // R1: start only while select low
          if (!sel_s) begin
            // R2: direction picks read or write
            if (rdwr_s) begin
              // R4: drive selected register, R8 address
              rdata_next = regs_reg[addr_s];
              oe_next    = 1'b1;
            // R11: check only when enabled
            end else if (pen_s && !par_ok) begin
              // R15: inhibit write, flag error
              regs_next[ICR_ADDR][PERR_BIT] = 1'b1;
            end else if (addr_s == ICR_ADDR) begin
              // condition bits clear by writing ones; new events still win
              regs_next[ICR_ADDR] = (regs_reg[ICR_ADDR] & ~data_s) | cond_events_i;
            end else begin
              regs_next[addr_s] = data_s;
            end
            // R3: completion via acknowledge
            ack_next   = 1'b1;
            state_next = ST_ACK;
          end
        end
        ST_ACK: begin
          // R6: hold acknowledge while select low
          if (sel_s) begin
            // R16: release ack and bus
            ack_next   = 1'b0;
            oe_next    = 1'b0;
            state_next = ST_IDLE;
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
    // R12: parity follows the read byte, whatever the enable
    par_next = ~^rdata_next;
  end

  // R9: mask gates the interrupt
  always_comb begin
    int_next = |(regs_next[ICR_ADDR] & ~regs_next[INTERRUPT_CONDITION_MASK_REG_ADDR]);
  end

  // interrupt register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      int_reg <= 1'b0;
    end else begin
      int_reg <= int_next;
    end
  end

  // state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_reg[i] <= REG_RESET_VAL;
      end
      rdata_reg <= 8'h00;
      oe_reg    <= 1'b0;
      ack_reg   <= 1'b0;
      par_reg   <= 1'b1;
    end else begin
      state_reg <= state_next;
      regs_reg  <= regs_next;
      rdata_reg <= rdata_next;
      oe_reg    <= oe_next;
      ack_reg   <= ack_next;
      par_reg   <= par_next;
    end
  end

  // R12: read parity always generated, R14 held with data
  assign bus.dev_data_o  = rdata_reg;
  assign bus.dev_par_o   = par_reg;
  assign bus.dev_data_oe = oe_reg;
  assign bus.ack_pull    = ack_reg;
  assign bus.int_pull    = int_reg;
  assign cond_status_o   = regs_reg[ICR_ADDR];
endmodule // mgmt_port_device

// ===== inc/mgmt_bus_pkg.sv
// Purpose: shared constants for the management control bus port
// Assumes: one 20 MHz clock on both ends
// Notes:   all counts are in cycles of clk_i
package mgmt_bus_pkg;
  localparam int          ADDR_W          = 5;
  localparam int          DATA_W          = 8;
  localparam int          NUM_REGS        = 32;
  // interrupt condition and mask register addresses
  localparam logic [4:0]  ICR_ADDR        = 5'h07;
  localparam logic [4:0]  INTERRUPT_CONDITION_MASK_REG_ADDR       = 5'h08;
  // bit position of the bus parity error flag in the condition register
  localparam int          PERR_BIT        = 0;
  localparam logic [7:0]  REG_RESET_VAL   = 8'h00;
  localparam logic [7:0]  INTERRUPT_CONDITION_MASK_REG_RESET_VAL  = 8'h00;
  // clock rate and the sampling enable rate of the device
  localparam int          CLK_HZ          = 20_000_000;
  localparam int          SAMPLE_HZ       = 12_500_000;
  // host time-out while waiting for the acknowledge, in cycles
  localparam int          HOST_TIMEOUT    = 64;
endpackage : mgmt_bus_pkg

// ===== inc/mgmt_bus_if.sv
// Purpose: pin bundle between management host and device port
// Assumes: open-drain and two-way pins resolved here from the enables
// Notes:   ack and int lines idle high through the pull-up
`timescale 1ns/1ps
interface mgmt_bus_if;
  logic       sel_n;
  logic       rd_wr;
  logic [4:0] mgmt_addr;
  // data bus and parity, both ends drive with enables
  logic [7:0] host_data_o;
  logic       host_data_oe;
  logic [7:0] dev_data_o;
  logic       dev_data_oe;
  logic       host_par_o;
  logic       dev_par_o;
  logic [7:0] mgmt_data;
  logic       mgmt_parity;
  // open-drain acknowledge and interrupt
  logic       ack_pull;
  logic       int_pull;
  logic       ack_n;
  logic       int_n;
  // wire resolution from enables
  assign mgmt_data   = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 8'hFF);
  assign mgmt_parity = dev_data_oe ? dev_par_o  : (host_data_oe ? host_par_o  : 1'b1);
  assign ack_n       = ~ack_pull;
  assign int_n       = ~int_pull;
  modport host (output sel_n, rd_wr, mgmt_addr, host_data_o, host_data_oe, host_par_o,
                input  mgmt_data, mgmt_parity, ack_n, int_n);
  modport device (input  sel_n, rd_wr, mgmt_addr, mgmt_data, mgmt_parity,
                  output dev_data_o, dev_data_oe, dev_par_o, ack_pull, int_pull);
endinterface : mgmt_bus_if

// ===== rtl/mgmt_port_host.sv
// Purpose: host end of the management bus, one access per request
// Assumes: device answers with ack; pins driven from flip-flops
// Notes:   time-out ends a cycle with no answer
`timescale 1ns/1ps
module mgmt_port_host
  import mgmt_bus_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // bus pins
  mgmt_bus_if.host        bus,
  // user request
  input  wire logic       req_i,
  input  wire logic       req_read_i,
  input  wire logic [4:0] req_addr_i,
  input  wire logic [7:0] req_wdata_i,
  input  wire logic       bad_parity_i,
  // user answer
  output logic            busy_o,
  output logic            done_o,
  output logic            timeout_o,
  output logic      [7:0] rdata_o,
  output logic            rparity_err_o,
  output logic            irq_o
);
  typedef enum logic [3:0] {
    H_IDLE  = 4'b0001,
    H_SETUP = 4'b0010,
    H_WAIT  = 4'b0100,
    H_END   = 4'b1000
  } host_state_t;

  host_state_t state_reg, state_next;
  logic       sel_reg, sel_next, rw_reg, rw_next, oe_reg, oe_next, par_reg, par_next;
  logic [4:0] addr_reg, addr_next;
  logic [7:0] wd_reg, wd_next, rd_reg, rd_next;
  logic       done_reg, done_next, to_reg, to_next, perr_reg, perr_next;
  logic [6:0] cnt_reg, cnt_next;
  logic [1:0] ack_sy, int_sy;
  logic [7:0] dm_reg, ds_reg;
  logic       pm_reg, ps_reg;
  logic       busy_reg, busy_next, irq_reg;

  // synchronise answers from the device pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_sy <= 2'b11;
      int_sy <= 2'b11;
      dm_reg <= 8'h00;
      ds_reg <= 8'h00;
      pm_reg <= 1'b0;
      ps_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      ack_sy <= {ack_sy[0], bus.ack_n};
      int_sy <= {int_sy[0], bus.int_n};
      dm_reg <= bus.mgmt_data;
      ds_reg <= dm_reg;
      pm_reg <= bus.mgmt_parity;
      ps_reg <= pm_reg;
      irq_reg <= ~int_sy[1];
    end
  end

  // cycle sequencing
  always_comb begin
    state_next = state_reg;
    sel_next = sel_reg;
    rw_next  = rw_reg;
    oe_next  = oe_reg;
    par_next = par_reg;
    addr_next = addr_reg;
    wd_next  = wd_reg;
    rd_next  = rd_reg;
    perr_next = perr_reg;
    done_next = 1'b0;
    to_next  = 1'b0;
    cnt_next = cnt_reg;
    case (state_reg)
      H_IDLE: if (req_i) begin
        // R1: set up everything before select
        rw_next   = req_read_i;
        addr_next = req_addr_i;
        wd_next   = req_wdata_i;
        par_next  = (~^req_wdata_i) ^ bad_parity_i;
        oe_next   = ~req_read_i;
        state_next = H_SETUP;
      end
      H_SETUP: begin
        sel_next = 1'b1;
        cnt_next = 7'h00;
        state_next = H_WAIT;
      end
      H_WAIT: begin
        cnt_next = cnt_reg + 7'h01;
        // R5: hold data until acknowledge
        if (!ack_sy[1]) begin
          rd_next   = ds_reg;
          perr_next = rw_reg & ~(^{ds_reg, ps_reg});
          sel_next  = 1'b0;
          done_next = 1'b1;
          state_next = H_END;
        end else if (cnt_reg == 7'(HOST_TIMEOUT)) begin
          sel_next = 1'b0;
          to_next  = 1'b1;
          state_next = H_END;
        end
      end
      H_END: begin
        oe_next = 1'b0;
        if (ack_sy[1]) state_next = H_IDLE;
      end
      default: state_next = H_IDLE;
    endcase
    // busy registered so the output comes from a flip-flop
    busy_next = (state_next != H_IDLE);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= H_IDLE;
      {sel_reg, rw_reg, oe_reg, par_reg, done_reg, to_reg, perr_reg} <= 7'h00;
      addr_reg <= 5'h00;
      wd_reg   <= 8'h00;
      rd_reg   <= 8'h00;
      cnt_reg  <= 7'h00;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sel_reg  <= sel_next;
      rw_reg   <= rw_next;
      oe_reg   <= oe_next;
      par_reg  <= par_next;
      addr_reg <= addr_next;
      wd_reg   <= wd_next;
      rd_reg   <= rd_next;
      perr_reg <= perr_next;
      done_reg <= done_next;
      to_reg   <= to_next;
      cnt_reg  <= cnt_next;
      busy_reg <= busy_next;
    end
  end

  assign bus.sel_n        = ~sel_reg;
  assign bus.rd_wr        = rw_reg;
  assign bus.mgmt_addr    = addr_reg;
  assign bus.host_data_o  = wd_reg;
  assign bus.host_data_oe = oe_reg;
  assign bus.host_par_o   = par_reg;
  assign busy_o        = busy_reg;
  assign done_o        = done_reg;
  assign timeout_o     = to_reg;
  assign rdata_o       = rd_reg;
  assign rparity_err_o = perr_reg;
  // R10: interrupt seen; read condition register
  assign irq_o         = irq_reg;
endmodule // mgmt_port_host

// ===== sim/mgmt_port_asserts.sv
// Purpose: pin-level checks on the management bus between the two ends
// Assumes: one clock, synchronous active-high reset
// Notes:   watches only the resolved bus pins and the device data enable
`timescale 1ns/1ps
module mgmt_port_asserts (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // bus pins
  input wire logic       sel_n,
  input wire logic       rd_wr,
  input wire logic [7:0] mgmt_data,
  input wire logic       mgmt_parity,
  input wire logic       ack_n,
  input wire logic       dev_data_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // acknowledge stays low while selected
  property p_ack_hold; !ack_n && !sel_n |=> !ack_n; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack released while selected");
  // acknowledge only falls inside a selected cycle
  property p_ack_sel; $fell(ack_n) |-> !sel_n && !$past(sel_n); endproperty
  a_ack_sel: assert property (p_ack_sel) else $error("ack without select");
  // every cycle is answered in bounded time
  property p_ack_due; $fell(sel_n) |-> ##[1:8] !ack_n; endproperty
  a_ack_due: assert property (p_ack_due) else $error("no ack after select");
  // synchronised select cannot answer at once
  property p_ack_sync; $fell(sel_n) |-> ack_n [*2]; endproperty
  a_ack_sync: assert property (p_ack_sync) else $error("ack faster than sync");
  // read data stands while ack is low
  property p_rd_stable; !ack_n && !$past(ack_n) && rd_wr |-> $stable(mgmt_data); endproperty
  a_rd_stable: assert property (p_rd_stable) else $error("read data moved");
  // read parity odd and driven while ack low
  property p_rd_par; !ack_n && rd_wr |-> dev_data_oe && (^{mgmt_data, mgmt_parity}); endproperty
  a_rd_par: assert property (p_rd_par) else $error("read parity wrong");
  // device never drives on a write
  property p_wr_quiet; !sel_n && !rd_wr |-> !dev_data_oe; endproperty
  a_wr_quiet: assert property (p_wr_quiet) else $error("device drove on write");
  // deselect releases ack and data
  property p_release; $rose(sel_n) |-> ##[1:8] (ack_n && !dev_data_oe); endproperty
  a_release: assert property (p_release) else $error("bus not released");
  // direction holds while selected
  property p_dir_hold; !sel_n && !$past(sel_n) |-> $stable(rd_wr); endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved");
  // write data and parity hold until acknowledge
  property p_wr_hold;
    !sel_n && !$past(sel_n) && $past(ack_n) && !rd_wr |->
      $stable(mgmt_data) && $stable(mgmt_parity);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write data moved");
endmodule // mgmt_port_asserts

// ===== sim/tb.sv
// Purpose: host and device ends joined, driven through the host user side and the device event and parity-enable inputs
// Assumes: 20 MHz clock, reset held two cycles
// Notes:   expected values worked out from reset values, register writes and events made here
`timescale 1ns/1ps
module tb;
  import mgmt_bus_pkg::*;
  logic       clk_i, rst_i, req_i, req_read_i, bad_parity_i, write_parity_check_en_i;
  logic [4:0] req_addr_i;
  logic [7:0] req_wdata_i, cond_events_i, cond_status_o, rdata_o, q;
  logic       busy_o, done_o, timeout_o, rparity_err_o, irq_o;
  int         n_fail, total_checks;
  logic [4:0] addrs [4] = '{5'h00, 5'h05, 5'h10, 5'h1F};
  mgmt_bus_if bus ();
  mgmt_port_host u_mgmt_port_host (.clk_i(clk_i), .rst_i(rst_i), .bus(bus), .req_i(req_i),
    .req_read_i(req_read_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .bad_parity_i(bad_parity_i), .busy_o(busy_o), .done_o(done_o), .timeout_o(timeout_o),
    .rdata_o(rdata_o), .rparity_err_o(rparity_err_o), .irq_o(irq_o));
  mgmt_port_device u_mgmt_port_device (.clk_i(clk_i), .rst_i(rst_i), .bus(bus),
    .write_parity_check_en_i(write_parity_check_en_i), .cond_events_i(cond_events_i),
    .cond_status_o(cond_status_o));
  mgmt_port_asserts u_mgmt_port_asserts (.clk_i(clk_i), .rst_i(rst_i), .sel_n(bus.sel_n),
    .rd_wr(bus.rd_wr), .mgmt_data(bus.mgmt_data), .mgmt_parity(bus.mgmt_parity),
    .ack_n(bus.ack_n), .dev_data_oe(bus.dev_data_oe));
  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // compare one value
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one bus access through the host, bounded wait for done then idle
  task automatic acc(input logic rd, input logic [4:0] a, input logic [7:0] d,
                     input logic bp, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    req_i       <= 1'h1;
    req_read_i  <= rd;
    req_addr_i  <= a;
    req_wdata_i <= d;
    bad_parity_i <= bp;
    @(posedge clk_i);
    req_i <= 1'h0;
    while (done_o !== 1'h1 && timeout_o !== 1'h1 && n < 200) begin @(posedge clk_i); n++; end
    r = rdata_o;
    chk({7'h00, timeout_o | (rd & rparity_err_o)}, 8'h00);
    while (busy_o !== 1'h0 && n < 200) begin @(posedge clk_i); n++; end
    if (n >= 200) begin n_fail++; finish_test(); end
  endtask
  // bounded wait for the interrupt level
  task automatic wait_irq(input logic e);
    int n;
    n = 0;
    while (irq_o !== e && n < 40) begin @(posedge clk_i); n++; end
    chk({7'h00, irq_o}, {7'h00, e});
  endtask
  // clock
  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  // main sequence
  initial begin
    {rst_i, write_parity_check_en_i} = 2'h3;
    {req_i, req_read_i, bad_parity_i} = 3'h0;
    req_addr_i = 5'h00; req_wdata_i = 8'h00; cond_events_i = 8'h00;
    n_fail = 0; total_checks = 0;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    acc(1'h1, 5'h03, 8'h00, 1'h0, q); chk(q, REG_RESET_VAL);
    acc(1'h1, INTERRUPT_CONDITION_MASK_REG_ADDR, 8'h00, 1'h0, q); chk(q, INTERRUPT_CONDITION_MASK_REG_RESET_VAL);
    foreach (addrs[i]) acc(1'h0, addrs[i], 8'hC3 ^ {3'h0, addrs[i]}, 1'h0, q);
    foreach (addrs[i]) begin
      acc(1'h1, addrs[i], 8'h00, 1'h0, q);
      chk(q, 8'hC3 ^ {3'h0, addrs[i]});
    end
    @(posedge clk_i) cond_events_i <= 8'h08;
    @(posedge clk_i) cond_events_i <= 8'h00;
    wait_irq(1'h1);
    acc(1'h1, ICR_ADDR, 8'h00, 1'h0, q); chk(q, 8'h08);
    acc(1'h0, INTERRUPT_CONDITION_MASK_REG_ADDR, 8'h08, 1'h0, q);
    wait_irq(1'h0);
    acc(1'h0, 5'h05, 8'h3C, 1'h1, q);
    acc(1'h1, 5'h05, 8'h00, 1'h0, q); chk(q, 8'hC6);
    chk(cond_status_o, 8'h09);
    wait_irq(1'h1);
    acc(1'h0, ICR_ADDR, 8'hFF, 1'h0, q); chk(cond_status_o, 8'h00);
    wait_irq(1'h0);
    @(posedge clk_i) write_parity_check_en_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    acc(1'h0, 5'h05, 8'h3C, 1'h1, q);
    acc(1'h1, 5'h05, 8'h00, 1'h0, q); chk(q, 8'h3C);
    chk(cond_status_o, 8'h00);
    finish_test();
  end
endmodule // tb
